// File: verification/sspr_bank_props.sv
// Port-level properties of the setpoint register bank.
// Assumes it is bound to the bank and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sspr_bank_props
    import sspr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Host ports
    input wire logic wr_en,
    input wire sspr_addr_t wr_addr,
    input wire sspr_word_t wr_data,
    input wire logic rd_en,
    input wire sspr_addr_t rd_addr,
    input wire sspr_word_t rd_data,
    input wire logic rd_valid,
    // Regulator side
    input wire logic output_on,
    input wire logic float_fmt,
    input wire sspr_val_t volt_target_pair,
    input wire sspr_val_t amp_target_pair,
    input wire sspr_val_t watt_target_pair,
    input wire logic [SSPR_NPAIR-1:0] target_update,
    input wire logic meas_valid,
    input wire sspr_val_t volt_meas_pair,
    input wire sspr_val_t amp_meas_pair,
    input wire sspr_val_t watt_meas_pair,
    input wire logic fault_flag,
    input wire logic [1:0] reg_mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    property p_rd_ans; rd_en |=> rd_valid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
    property p_rd_idle; !rd_en |=> !rd_valid; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read valid");
    property p_on;
        wr_en && wr_addr == SSPR_CMD_ADDR |=> output_on == $past(wr_data[1]);
    endproperty
    a_on: assert property (p_on) else $error("output enable wrong");
    property p_fmt;
        wr_en && wr_addr == SSPR_CMD_ADDR |=> float_fmt == $past(wr_data[7]);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format select wrong");
    property p_stat;
        rd_en && rd_addr == SSPR_STATE_ADDR |=> rd_data == {11'h000,
            $past(float_fmt), $past(reg_mode), $past(fault_flag), $past(output_on)};
    endproperty
    a_stat: assert property (p_stat) else $error("status word wrong");
    property p_unm;
        rd_en && (rd_addr inside {8'h01, 8'h02} || rd_addr > 8'h08) |=> rd_data == 16'h0000;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read nonzero");
    property p_upd_v;
        target_update[0] |-> $past(wr_en) && $past(wr_addr) inside {8'h01, 8'h02};
    endproperty
    a_upd_v: assert property (p_upd_v) else $error("volt commit uncaused");
    property p_lo_v;
        target_update[0] && $past(wr_addr) == 8'h02 |-> volt_target_pair[15:0] == $past(wr_data);
    endproperty
    a_lo_v: assert property (p_lo_v) else $error("volt low half wrong");
    property p_pulse; target_update[1] |=> !target_update[1]; endproperty
    a_pulse: assert property (p_pulse) else $error("commit pulse long");
    property p_hold; !target_update[2] |-> $stable(watt_target_pair); endproperty
    a_hold: assert property (p_hold) else $error("power target moved");
    c_volt: cover property (target_update[0]);
    c_watt: cover property (target_update[2]);
    c_lo: cover property (rd_en && rd_addr == SSPR_VOLT_MEAS_LO_ADDR);
endmodule
`default_nettype wire

// File: verification/sspr_meas_src.sv
// Regulator feedback model: a new measurement set on each request.
// Assumes the bank clock; sample is a one-cycle pulse from the bench.
`timescale 1ns/1ps
`default_nettype none
module sspr_meas_src
    import sspr_pkg::*;
(
    // Clock and control
    input wire logic clock,
    input wire logic srst,
    input wire logic sample,
    // Feedback
    output logic meas_valid,
    output sspr_val_t volt,
    output sspr_val_t amp,
    output sspr_val_t watt,
    output logic fault,
    output logic [1:0] mode
);
    logic [7:0] k;
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            k <= 8'h00;
            meas_valid <= 1'b0;
        end
        else
        begin
            meas_valid <= sample;
            k <= k + {7'h00, sample};
        end
    end
    // Halves differ so a torn pair shows up
    assign volt = {8'h10, k, 8'h20, k};
    assign amp = {8'h30, k, 8'h40, k};
    assign watt = {8'h50, k, 8'h60, k};
    assign fault = k[0];
    assign mode = k[2:1];
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the setpoint register bank.
// Assumes the feedback model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sspr_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic sample = 1'b0;
    sspr_addr_t wr_addr = 8'h00;
    sspr_addr_t rd_addr = 8'h00;
    sspr_word_t wr_data = 16'h0000;
    sspr_word_t rd_data;
    logic rd_valid, output_on, float_fmt, meas_valid, fault_flag;
    logic [1:0] reg_mode;
    logic [SSPR_NPAIR-1:0] target_update;
    logic [SSPR_NPAIR-1:0] upd_seen = 3'h0;
    sspr_val_t vt, at, wt, vm, am, wm;
    sspr_val_t tgt [3];
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] k = 8'h00;
    always #25 clock = ~clock;
    always_comb tgt = '{vt, at, wt};
    logic upd_clr = 1'b0;
    // One driver for the commit record; the stimulus clears it through upd_clr
    always @(posedge clock) upd_seen <= upd_clr ? 3'h0 : (upd_seen | target_update);
    sspr_bank sspr_bank_inst (.clock(clock), .srst(srst), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid), .output_on(output_on),
        .float_fmt(float_fmt), .volt_target_pair(vt), .amp_target_pair(at),
        .watt_target_pair(wt), .target_update(target_update),
        .meas_valid(meas_valid), .volt_meas_pair(vm), .amp_meas_pair(am),
        .watt_meas_pair(wm), .fault_flag(fault_flag), .reg_mode(reg_mode));
    sspr_meas_src sspr_meas_src_inst (.clock(clock), .srst(srst), .sample(sample),
        .meas_valid(meas_valid), .volt(vm), .amp(am), .watt(wm),
        .fault(fault_flag), .mode(reg_mode));
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Each access leaves one idle cycle so strobes never re-rise at once
    task automatic wr(input sspr_addr_t a, input sspr_word_t d);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clock);
        wr_en = 1'b0;
        @(negedge clock);
    endtask
    task automatic rd(input sspr_addr_t a, input sspr_word_t exp);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clock);
        rd_en = 1'b0;
        check(rd_valid, 1'b1);
        check(rd_data, exp);
        @(negedge clock);
    endtask
    task automatic snap();
        sample = 1'b1;
        @(negedge clock);
        sample = 1'b0;
        k++;
        @(negedge clock);
    endtask
    task automatic clr_upd();
        upd_clr = 1'b1;
        @(negedge clock);
        upd_clr = 1'b0;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (5) @(negedge clock);
        srst = 1'b0;
        check({output_on, float_fmt}, 2'b00);
        for (int i = 0; i < 4; i++)
        begin
            wr(SSPR_CMD_ADDR, {8'h00, i[1], 5'h00, i[0], 1'b0});
            check({float_fmt, output_on}, {i[1], i[0]});
            rd(SSPR_STATE_ADDR, {11'h000, i[1], 3'h0, i[0]});
        end
        for (int p = 0; p < 3; p++)
        begin
            clr_upd();
            wr(8'(2 * p + 1), 16'(p));
            check(upd_seen, 3'h0);
            check(tgt[p], SSPR_VAL_RESET);
            wr(8'(2 * p + 2), 16'h4000);
            check(upd_seen, 3'h1 << p);
            check(tgt[p], {16'(p), 16'h4000});
        end
        clr_upd();
        wr(8'h07, 16'hffff);
        wr(SSPR_VOLT_TGT_LO_ADDR, 16'h0000);
        check(upd_seen, 3'h0);
        wr(SSPR_VOLT_TGT_HI_ADDR, 16'h3f80);
        check(vt, 32'h3f80_0000);
        check(wt, 32'h0002_4000);
        snap();
        for (int p = 0; p < 3; p++)
        begin
            rd(8'(2 * p + 3), {8'(8'h10 + 32 * p), k});
            snap();
            rd(8'(2 * p + 4), {8'(8'h20 + 32 * p), k - 8'h01});
        end
        snap();
        rd(SSPR_STATE_ADDR, {11'h000, 1'b1, k[2:1], k[0], 1'b1});
        rd(8'h01, 16'h0000);
        rd(8'h02, 16'h0000);
        rd(8'h09, 16'h0000);
        // Mid-run reset, held long enough for sampled values to settle at zero
        srst = 1'b1;
        repeat (3) @(negedge clock);
        srst = 1'b0;
        check({output_on, float_fmt}, 2'b00);
        for (int p = 0; p < 3; p++)
        begin
            check(tgt[p], SSPR_VAL_RESET);
        end
        rd(SSPR_STATE_ADDR, 16'h0000);
        rd(SSPR_VOLT_MEAS_LO_ADDR, 16'h0000);
        wrap_up();
    end
endmodule
bind sspr_bank sspr_bank_props sspr_bank_props_inst (.clock(clock), .srst(srst),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .output_on(output_on),
    .float_fmt(float_fmt), .volt_target_pair(volt_target_pair),
    .amp_target_pair(amp_target_pair), .watt_target_pair(watt_target_pair),
    .target_update(target_update), .meas_valid(meas_valid),
    .volt_meas_pair(volt_meas_pair), .amp_meas_pair(amp_meas_pair),
    .watt_meas_pair(watt_meas_pair), .fault_flag(fault_flag), .reg_mode(reg_mode));
`default_nettype wire

// File: verilog/sspr_bank.sv
// Supply setpoint register bank: command, setpoints, status, measurements.
// Assumes write and read strobes and measurement inputs are already
// on this clock; the transport decoder lives outside.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Every register in both spaces is one 16-bit word.
// - Writes and reads use separate spaces even at a shared address.
// - Command bit 1 turns the output on when one, off when zero.
// - Command bit 7 selects float for setpoints, else Q15 fraction.
// - Q15 integer equals the real value times 32768.
// - Each 32-bit value is a pair: high half, low half.
// - Voltage setpoint at write 0x1/0x2; Q15 1.0 is full-scale voltage.
// - Current setpoint at write 0x3/0x4; Q15 1.0 is module full current.
// - Power setpoint at write 0x5/0x6; Q15 1.0 is module full power.
// - In float format setpoints are plain volts, amperes, watts.
// - Measured voltage reads at 0x3/0x4, voltage setpoint format.
// - Measured current reads at 0x5/0x6, current setpoint format.
// - Measured power reads at 0x7/0x8, power setpoint format.
// - Status at read 0x0 gives output state, fault, regulation mode.
// - Float format means IEEE single precision for all 32-bit values.
module sspr_bank
    import sspr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Host write port
    input wire logic wr_en,
    input wire sspr_addr_t wr_addr,
    input wire sspr_word_t wr_data,
    // Host read port
    input wire logic rd_en,
    input wire sspr_addr_t rd_addr,
    output sspr_word_t rd_data,
    output logic rd_valid,
    // Regulator controls
    output logic output_on,
    output logic float_fmt,
    output sspr_val_t volt_target_pair,
    output sspr_val_t amp_target_pair,
    output sspr_val_t watt_target_pair,
    output logic [SSPR_NPAIR-1:0] target_update,
    // Regulator feedback
    input wire logic meas_valid,
    input wire sspr_val_t volt_meas_pair,
    input wire sspr_val_t amp_meas_pair,
    input wire sspr_val_t watt_meas_pair,
    input wire logic fault_flag,
    input wire logic [1:0] reg_mode
);
    // Pair index 0 voltage, 1 current, 2 power in both spaces
    function automatic sspr_addr_t tgt_hi_addr(input int idx);
        sspr_addr_t base;
        base = SSPR_VOLT_TGT_HI_ADDR;
        unique case (idx)
            1: base = SSPR_AMP_TGT_HI_ADDR;
            2: base = SSPR_WATT_TGT_HI_ADDR;
            default: base = SSPR_VOLT_TGT_HI_ADDR;
        endcase
        return base;
    endfunction

    function automatic sspr_addr_t tgt_lo_addr(input int idx);
        sspr_addr_t base;
        base = SSPR_VOLT_TGT_LO_ADDR;
        unique case (idx)
            1: base = SSPR_AMP_TGT_LO_ADDR;
            2: base = SSPR_WATT_TGT_LO_ADDR;
            default: base = SSPR_VOLT_TGT_LO_ADDR;
        endcase
        return base;
    endfunction

    function automatic sspr_addr_t meas_hi_addr(input int idx);
        sspr_addr_t base;
        base = SSPR_VOLT_MEAS_HI_ADDR;
        unique case (idx)
            1: base = SSPR_AMP_MEAS_HI_ADDR;
            2: base = SSPR_WATT_MEAS_HI_ADDR;
            default: base = SSPR_VOLT_MEAS_HI_ADDR;
        endcase
        return base;
    endfunction

    function automatic sspr_addr_t meas_lo_addr(input int idx);
        sspr_addr_t base;
        base = SSPR_VOLT_MEAS_LO_ADDR;
        unique case (idx)
            1: base = SSPR_AMP_MEAS_LO_ADDR;
            2: base = SSPR_WATT_MEAS_LO_ADDR;
            default: base = SSPR_VOLT_MEAS_LO_ADDR;
        endcase
        return base;
    endfunction

    typedef struct packed {
        sspr_word_t cmd;
        logic [SSPR_NPAIR-1:0][SSPR_VAL_W-1:0] meas_hold;
        logic [SSPR_NPAIR-1:0][SSPR_HALF_W-1:0] lo_shadow;
        sspr_word_t rd_data;
        logic rd_valid;
    } sspr_bank_s;

    sspr_bank_s st_r;
    sspr_bank_s st_nxt;

    sspr_val_t meas_in [SSPR_NPAIR];
    sspr_word_t status_word;

    assign meas_in[0] = volt_meas_pair;
    assign meas_in[1] = amp_meas_pair;
    assign meas_in[2] = watt_meas_pair;

    // Setpoint pairs, one latch each
    sspr_pair_if pif [SSPR_NPAIR] ();

    genvar g;
    generate
        for (g = 0; g < SSPR_NPAIR; g++)
        begin : g_pair
            // Write space only; a read at the same address never lands here
            assign pif[g].wr_hi = wr_en && (wr_addr == tgt_hi_addr(g));
            assign pif[g].wr_lo = wr_en && (wr_addr == tgt_lo_addr(g));
            assign pif[g].wdata = wr_data;
            assign target_update[g] = pif[g].commit;

            sspr_pair_latch u_latch
            (
                .clock(clock),
                .srst(srst),
                .port(pif[g])
            );
        end
    endgenerate

    // Raw 32-bit words; format and full-scale meaning rest on float_fmt
    assign volt_target_pair = pif[0].value;
    assign amp_target_pair = pif[1].value;
    assign watt_target_pair = pif[2].value;

    always_comb
    begin
        status_word = SSPR_WORD_RESET;
        status_word[SSPR_ST_ON_BIT] = st_r.cmd[SSPR_CMD_ON_BIT];
        status_word[SSPR_ST_FAULT_BIT] = fault_flag;
        status_word[SSPR_ST_MODE_LSB +: 2] = reg_mode;
        status_word[SSPR_ST_FLOAT_BIT] = st_r.cmd[SSPR_CMD_FLOAT_BIT];
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;

        // Command word write; all sixteen bits kept for other consumers
        if (wr_en && (wr_addr == SSPR_CMD_ADDR))
        begin
            st_nxt.cmd = wr_data;
        end

        // Hold measurements until the regulator offers a new set
        if (meas_valid)
        begin
            for (int i = 0; i < SSPR_NPAIR; i++)
            begin
                st_nxt.meas_hold[i] = meas_in[i];
            end
        end

        if (rd_en)
        begin
            st_nxt.rd_valid = 1'b1;
            st_nxt.rd_data = SSPR_WORD_RESET;
            if (rd_addr == SSPR_STATE_ADDR)
            begin
                st_nxt.rd_data = status_word;
            end
            for (int i = 0; i < SSPR_NPAIR; i++)
            begin
                // High read freezes the low half of the same sample
                if (rd_addr == meas_hi_addr(i))
                begin
                    st_nxt.rd_data = st_r.meas_hold[i][SSPR_VAL_W-1 -: SSPR_HALF_W];
                    st_nxt.lo_shadow[i] = st_r.meas_hold[i][SSPR_HALF_W-1:0];
                end
                // Low read returns the frozen half, never a newer sample
                if (rd_addr == meas_lo_addr(i))
                begin
                    st_nxt.rd_data = st_r.lo_shadow[i];
                end
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            st_r.cmd <= SSPR_CMD_RESET;
            st_r.meas_hold <= '0;
            st_r.lo_shadow <= '0;
            st_r.rd_data <= SSPR_WORD_RESET;
            st_r.rd_valid <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Measurements share the setpoint format, so one flag serves both
    assign output_on = st_r.cmd[SSPR_CMD_ON_BIT];
    assign float_fmt = st_r.cmd[SSPR_CMD_FLOAT_BIT];
    assign rd_data = st_r.rd_data;
    assign rd_valid = st_r.rd_valid;
endmodule
`default_nettype wire

// File: verilog/sspr_pair_if.sv
// Carrier between the bank and one setpoint pair latch.
// Assumes both ends share the bank clock.
`timescale 1ns/1ps
`default_nettype none
interface sspr_pair_if;
    import sspr_pkg::*;
    logic wr_hi;
    logic wr_lo;
    sspr_word_t wdata;
    sspr_val_t value;
    logic commit;

    modport bank
    (
        output wr_hi,
        output wr_lo,
        output wdata,
        input value,
        input commit
    );
    modport pair
    (
        input wr_hi,
        input wr_lo,
        input wdata,
        output value,
        output commit
    );
endinterface
`default_nettype wire

// File: verilog/sspr_pair_latch.sv
// One 32-bit setpoint built from a high and a low half-word write.
// Assumes write strobes are one-cycle pulses on the bank clock.
`timescale 1ns/1ps
`default_nettype none
module sspr_pair_latch
    import sspr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Bank side
    sspr_pair_if.pair port
);
    typedef struct packed {
        logic hi_seen;
        logic lo_seen;
        sspr_word_t hi_hold;
        sspr_word_t lo_hold;
        sspr_val_t value;
        logic commit;
    } sspr_pair_s;

    sspr_pair_s st_r;
    sspr_pair_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.commit = 1'b0;
        if (port.wr_hi)
        begin
            st_nxt.hi_hold = port.wdata;
            st_nxt.hi_seen = 1'b1;
        end
        if (port.wr_lo)
        begin
            st_nxt.lo_hold = port.wdata;
            st_nxt.lo_seen = 1'b1;
        end
        // Either order works; a half alone never reaches the regulator
        if (st_nxt.hi_seen && st_nxt.lo_seen)
        begin
            st_nxt.value = {st_nxt.hi_hold, st_nxt.lo_hold};
            st_nxt.commit = 1'b1;
            st_nxt.hi_seen = 1'b0;
            st_nxt.lo_seen = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign port.value = st_r.value;
    assign port.commit = st_r.commit;
endmodule
`default_nettype wire

// File: verilog/sspr_pkg.sv
// Constants and types for the supply setpoint register bank.
// Assumes one clock domain; every user of it imports the whole package.
package sspr_pkg;

    // Bus widths
    localparam int SSPR_WORD_W = 16;
    localparam int SSPR_ADDR_W = 8;
    localparam int SSPR_VAL_W = 32;
    localparam int SSPR_NPAIR = 3;

    typedef logic [SSPR_ADDR_W-1:0] sspr_addr_t;
    typedef logic [SSPR_WORD_W-1:0] sspr_word_t;
    typedef logic [SSPR_VAL_W-1:0] sspr_val_t;

    // Write space offsets
    localparam sspr_addr_t SSPR_CMD_ADDR = 8'h00;
    localparam sspr_addr_t SSPR_VOLT_TGT_HI_ADDR = 8'h01;
    localparam sspr_addr_t SSPR_VOLT_TGT_LO_ADDR = 8'h02;
    localparam sspr_addr_t SSPR_AMP_TGT_HI_ADDR = 8'h03;
    localparam sspr_addr_t SSPR_AMP_TGT_LO_ADDR = 8'h04;
    localparam sspr_addr_t SSPR_WATT_TGT_HI_ADDR = 8'h05;
    localparam sspr_addr_t SSPR_WATT_TGT_LO_ADDR = 8'h06;

    // Read space offsets
    localparam sspr_addr_t SSPR_STATE_ADDR = 8'h00;
    localparam sspr_addr_t SSPR_VOLT_MEAS_HI_ADDR = 8'h03;
    localparam sspr_addr_t SSPR_VOLT_MEAS_LO_ADDR = 8'h04;
    localparam sspr_addr_t SSPR_AMP_MEAS_HI_ADDR = 8'h05;
    localparam sspr_addr_t SSPR_AMP_MEAS_LO_ADDR = 8'h06;
    localparam sspr_addr_t SSPR_WATT_MEAS_HI_ADDR = 8'h07;
    localparam sspr_addr_t SSPR_WATT_MEAS_LO_ADDR = 8'h08;

    // Command word fields
    localparam int SSPR_CMD_ON_BIT = 1;
    localparam int SSPR_CMD_FLOAT_BIT = 7;
    localparam sspr_word_t SSPR_CMD_RESET = 16'h0000;

    // Status word fields
    localparam int SSPR_ST_ON_BIT = 0;
    localparam int SSPR_ST_FAULT_BIT = 1;
    localparam int SSPR_ST_MODE_LSB = 2;
    localparam int SSPR_ST_FLOAT_BIT = 4;

    // Value halves and fractional scale: real = integer / 2**15
    localparam int SSPR_HALF_W = 16;
    localparam int SSPR_Q15_FRAC_BITS = 15;
    localparam sspr_val_t SSPR_Q15_ONE = 32'h0000_8000;
    localparam sspr_val_t SSPR_VAL_RESET = 32'h0000_0000;
    localparam sspr_word_t SSPR_WORD_RESET = 16'h0000;

endpackage
